// ---- design/osr_map.svh ----
// Register map constants for the sysref output state bank.
// Assumes an Avalon-MM slave with byte addresses, one word per register.
`ifndef OSR_MAP_SVH
`define OSR_MAP_SVH
// Register indices; byte address is four times the index
`define OSR_IDX_A0_SRC 8'h28
`define OSR_IDX_A1_SRC 8'h29
`define OSR_IDX_A2_SRC 8'h2A
`define OSR_IDX_A0_DRV 8'h2C
`define OSR_IDX_A1_DRV 8'h2D
`define OSR_IDX_A2_DRV 8'h2E
`define OSR_IDX_B0_SRC 8'h38
`define OSR_IDX_B1_SRC 8'h39
`define OSR_IDX_B0_DRV 8'h3C
`define OSR_IDX_B1_DRV 8'h3D
`define OSR_IDX_C0_SRC 8'h48
`define OSR_IDX_C1_SRC 8'h49
`define OSR_IDX_C0_DRV 8'h4C
`define OSR_IDX_C1_DRV 8'h4D
`define OSR_IDX_D_SRC 8'h58
`define OSR_IDX_D_DRV 8'h5C
`define OSR_IDX_GATES 8'h76
// Field positions in the source/delay register
`define OSR_SRC_BIT 4
`define OSR_DLY_HI 3
`define OSR_DLY_LO 1
// Field positions in the driver state register
`define OSR_PD_BIT 7
`define OSR_BIAS_BIT 5
`define OSR_STYLE_BIT 4
`define OSR_AMP_HI 3
`define OSR_AMP_LO 2
// Reset values
`define OSR_SRC_RST 1'b1
`define OSR_DLY_RST 3'h0
`define OSR_PD_RST 1'b0
`define OSR_BIAS_RST 1'b0
`define OSR_STYLE_RST 1'b0
`define OSR_AMP_RST 2'h0
`define OSR_GATE_RST 1'b0
// Bank geometry and timing
`define OSR_NUM_OUT 8
`define OSR_NUM_CHAN 4
`define OSR_MAX_DLY 7
`endif

// ---- design/osr_pkg.sv ----
// Types shared by the sysref output state bank.
// Assumes osr_map.svh is on the include path.
package osr_pkg;
  // Kind of register hit by an address
  typedef enum logic [1:0] {
    OSR_REG_NONE = 2'b00,
    OSR_REG_SRC = 2'b01,
    OSR_REG_DRV = 2'b10,
    OSR_REG_GATE = 2'b11
  } osr_kind_t;
  // Result of decoding a register index
  typedef struct packed {
    osr_kind_t kind;
    logic [2:0] num;
  } osr_dec_t;
  // Bus handshake state
  typedef enum logic {
    OSR_BUS_IDLE = 1'b0,
    OSR_BUS_ACK = 1'b1
  } osr_bus_t;
endpackage : osr_pkg

// ---- design/osr_out_stage.sv ----
// One sysref output path: source select, phase delay, gating.
// Assumes inputs are already synchronised to clk.
`timescale 1ns/1ps
`include "osr_map.svh"
module osr_out_stage
  import osr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic chan_clk,
  input wire logic sysref,
  input wire logic src_sel,
  input wire logic [2:0] phase_dly,
  input wire logic power_down,
  input wire logic gate,
  output logic q
);
  // Selected source level
  logic src_lvl;
  // History of the selected source, newest at bit 0
  logic [`OSR_MAX_DLY-1:0] hist;
  // Taps: current value plus delayed copies
  logic [`OSR_MAX_DLY:0] taps;

  // Low picks the channel clock, high the sysref
  assign src_lvl = src_sel ? sysref : chan_clk;
  assign taps = {hist, src_lvl};

  // Delay line, one clk cycle per delay step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hist <= '0;
    end else begin
      hist <= taps[`OSR_MAX_DLY-1:0];
    end
  end

  // Disabled or powered-down outputs sit static low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= 1'b0;
    end else if (!gate || power_down) begin
      q <= 1'b0;
    end else begin
      q <= taps[phase_dly];
    end
  end
endmodule : osr_out_stage

// ---- design/osr_regs.sv ----
// Sysref output state register bank with eight output paths.
// Assumes an Avalon-MM master on clk; pin inputs are asynchronous.
//
// Functional notes
// - Each output applies its stored source, delay, driver settings.
// - Power D7, bias D5, style D4, amplitude D3:D2.
// - Style clear LVDS, set PECL; reset LVDS.
// - Gate cleared holds output low; reset disabled.
// - Source select clear is channel clock; reset sysref.
`timescale 1ns/1ps
`include "osr_map.svh"
module osr_regs
  import osr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave, byte addressed
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Asynchronous signal inputs
  input wire logic sysref_in,
  input wire logic [3:0] chan_clk_in,
  // Sysref output levels, A0 at bit 0
  output logic [7:0] sysref_output,
  // Per-output settings for the analog drivers
  output logic [7:0] sysref_src_sel,
  output logic [7:0][2:0] sysref_phase_dly,
  output logic [7:0] out_power_down,
  output logic [7:0] bias_ctrl_n,
  output logic [7:0] drv_style_pecl,
  output logic [7:0][1:0] drv_amplitude,
  output logic [7:0] sysref_out_gate
);

  // Map a register index to its kind and output number.
  // Unknown indices decode to NONE, so writes there drop silently.
  function automatic osr_dec_t osr_decode(input logic [7:0] idx);
    osr_dec_t d;
    d.kind = OSR_REG_NONE;
    d.num = 3'h0;
    case (idx)
      // Channel A source and delay
      `OSR_IDX_A0_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h0;
      end
      `OSR_IDX_A1_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h1;
      end
      `OSR_IDX_A2_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h2;
      end
      // Channel B source and delay
      `OSR_IDX_B0_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h3;
      end
      `OSR_IDX_B1_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h4;
      end
      // Channel C source and delay
      `OSR_IDX_C0_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h5;
      end
      `OSR_IDX_C1_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h6;
      end
      // Channel D source and delay
      `OSR_IDX_D_SRC: begin
        d.kind = OSR_REG_SRC;
        d.num = 3'h7;
      end
      // Channel A driver state
      `OSR_IDX_A0_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h0;
      end
      `OSR_IDX_A1_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h1;
      end
      `OSR_IDX_A2_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h2;
      end
      // Channel B driver state
      `OSR_IDX_B0_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h3;
      end
      `OSR_IDX_B1_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h4;
      end
      // Channel C driver state
      `OSR_IDX_C0_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h5;
      end
      `OSR_IDX_C1_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h6;
      end
      // Channel D driver state
      `OSR_IDX_D_DRV: begin
        d.kind = OSR_REG_DRV;
        d.num = 3'h7;
      end
      // Shared gate register for all eight outputs
      `OSR_IDX_GATES: begin
        d.kind = OSR_REG_GATE;
      end
      // Anything else is a hole in the map
      default: begin
        d.kind = OSR_REG_NONE;
      end
    endcase
    return d;
  endfunction : osr_decode

  // Channel feeding each output: A0-A2, B0-B1, C0-C1, D.
  // Used for every generated path, so the split lives in one place.
  function automatic logic [1:0] osr_chan_of(input int unsigned n);
    logic [1:0] c;
    // Output D is alone in the last channel
    c = 2'h3;
    if (n < 3) begin
      // Outputs A0 to A2
      c = 2'h0;
    end else if (n < 5) begin
      // Outputs B0 and B1
      c = 2'h1;
    end else if (n < 7) begin
      // Outputs C0 and C1
      c = 2'h2;
    end
    return c;
  endfunction : osr_chan_of

  // Bus handshake state
  osr_bus_t bus_state;
  // Decoded view of the current address
  osr_dec_t dec;
  // Write commits at the edge the master sees waitrequest low
  // A write with the low lane off completes but stores nothing
  logic wr_commit;
  // Read word assembled from the fields
  logic [7:0] rd_byte;

  // Synchroniser stages for {sysref, channel clocks}
  // Bit 4 is the sysref, bits 3:0 channels A to D
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  // Filtered levels, updated when stages two and three agree
  logic [4:0] sync_lvl;

  // Index is the byte address divided by four
  assign dec = osr_decode(avs_address[9:2]);

  // Low byte lane carries the 8-bit registers
  assign wr_commit = (bus_state == OSR_BUS_ACK) && avs_write && avs_byteenable[0];

  // Read mux; reserved bits read as zero
  always_comb begin
    // Default first so every path assigns the byte
    rd_byte = 8'h00;
    case (dec.kind)
      // Source at D4, delay at D3:D1
      OSR_REG_SRC: begin
        rd_byte[`OSR_SRC_BIT] = sysref_src_sel[dec.num];
        rd_byte[`OSR_DLY_HI:`OSR_DLY_LO] = sysref_phase_dly[dec.num];
      end
      // D6 and D1:D0 are reserved
      OSR_REG_DRV: begin
        rd_byte[`OSR_PD_BIT] = out_power_down[dec.num];
        rd_byte[`OSR_BIAS_BIT] = bias_ctrl_n[dec.num];
        rd_byte[`OSR_STYLE_BIT] = drv_style_pecl[dec.num];
        rd_byte[`OSR_AMP_HI:`OSR_AMP_LO] = drv_amplitude[dec.num];
      end
      OSR_REG_GATE: begin
        // A0 sits at D7, D at D0
        for (int i = 0; i < `OSR_NUM_OUT; i++) begin
          rd_byte[7 - i] = sysref_out_gate[i];
        end
      end
      // Holes in the map read back as zero
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Bus handshake: one wait cycle, then a one-cycle answer.
  // Registering the answer keeps waitrequest glitch-free
  // at the cost of one extra cycle per access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= OSR_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        OSR_BUS_IDLE: begin
          // Take a request and answer on the next edge
          if (avs_read || avs_write) begin
            bus_state <= OSR_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        OSR_BUS_ACK: begin
          // Master completes here and releases the request
          bus_state <= OSR_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          // Unreachable with two states; fall back to idle
          bus_state <= OSR_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data, captured as waitrequest drops
  // The word then stands until the next read is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else if (bus_state == OSR_BUS_IDLE && avs_read) begin
      // Unmapped indices answer with zero
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // Source select and phase delay fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Reset routes every output to the sysref
      sysref_src_sel <= {`OSR_NUM_OUT{`OSR_SRC_RST}};
      sysref_phase_dly <= {`OSR_NUM_OUT{`OSR_DLY_RST}};
    end else if (wr_commit && dec.kind == OSR_REG_SRC) begin
      // Only the addressed output changes
      sysref_src_sel[dec.num] <= avs_writedata[`OSR_SRC_BIT];
      sysref_phase_dly[dec.num] <= avs_writedata[`OSR_DLY_HI:`OSR_DLY_LO];
    end
  end

  // Driver state fields: power, bias, style, amplitude
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Powered up, bias low, smallest amplitude
      out_power_down <= {`OSR_NUM_OUT{`OSR_PD_RST}};
      bias_ctrl_n <= {`OSR_NUM_OUT{`OSR_BIAS_RST}};
      // Reset selects the LVDS driver
      drv_style_pecl <= {`OSR_NUM_OUT{`OSR_STYLE_RST}};
      drv_amplitude <= {`OSR_NUM_OUT{`OSR_AMP_RST}};
    end else if (wr_commit && dec.kind == OSR_REG_DRV) begin
      // Only the addressed output changes
      out_power_down[dec.num] <= avs_writedata[`OSR_PD_BIT];
      bias_ctrl_n[dec.num] <= avs_writedata[`OSR_BIAS_BIT];
      // Clear is LVDS, set is PECL
      drv_style_pecl[dec.num] <= avs_writedata[`OSR_STYLE_BIT];
      drv_amplitude[dec.num] <= avs_writedata[`OSR_AMP_HI:`OSR_AMP_LO];
    end
  end

  // Output gate register, A0 in the top bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // All outputs start disabled
      sysref_out_gate <= {`OSR_NUM_OUT{`OSR_GATE_RST}};
    end else if (wr_commit && dec.kind == OSR_REG_GATE) begin
      // One byte sets all eight gates at once
      for (int i = 0; i < `OSR_NUM_OUT; i++) begin
        sysref_out_gate[i] <= avs_writedata[7 - i];
      end
    end
  end

  // Three-stage synchroniser for the asynchronous inputs.
  // Stage one feeds only stage two, so metastability
  // never reaches the filter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Pins are taken as low out of reset
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end else begin
      sync1 <= {sysref_in, chan_clk_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_lvl <= 5'h00;
    end else begin
      for (int k = 0; k < 5; k++) begin
        // A disagreement keeps the last accepted level
        if (sync2[k] == sync3[k]) begin
          sync_lvl[k] <= sync3[k];
        end
      end
    end
  end

  // One path per output; each takes its channel's clock.
  // Phase delay is modelled in clk cycles, so the real
  // sub-nanosecond steps are only represented by order.
  // Outputs of one channel share a clock tap, so only the
  // delay code sets their relative phase.
  generate
    for (genvar g = 0; g < `OSR_NUM_OUT; g++) begin : g_out
      osr_out_stage u_stage (
        .clk(clk),
        .resetn(resetn),
        .chan_clk(sync_lvl[osr_chan_of(g)]),
        // Every path sees the same filtered sysref
        .sysref(sync_lvl[4]),
        .src_sel(sysref_src_sel[g]),
        .phase_dly(sysref_phase_dly[g]),
        .power_down(out_power_down[g]),
        .gate(sysref_out_gate[g]),
        .q(sysref_output[g])
      );
    end
  endgenerate

endmodule : osr_regs

// ---- tb/osr_regs_asserts.sv ----
// Port checker for the sysref output state bank.
// Assumes one clock, async active-low reset, bound into osr_regs.
`timescale 1ns/1ps
module osr_regs_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] sysref_output,
  input wire logic [7:0] sysref_src_sel,
  input wire logic [7:0][2:0] sysref_phase_dly,
  input wire logic [7:0] out_power_down,
  input wire logic [7:0] bias_ctrl_n,
  input wire logic [7:0] drv_style_pecl,
  input wire logic [7:0][1:0] drv_amplitude,
  input wire logic [7:0] sysref_out_gate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wcom; // Write commits at this edge
  logic [7:0] widx; // Register index
  logic [7:0] wd; // Low data byte
  assign wcom = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign widx = avs_address[9:2];
  assign wd = avs_writedata[7:0];
  // Gate register runs A0 at D7, so it is reversed against port order
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  req_answer_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("request not answered");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  gate_write_a: assert property (wcom && widx == 8'h76 |=> sysref_out_gate == rev8($past(wd)))
    else $error("gate write not applied");
  gate_read_a: assert property (avs_read && !avs_waitrequest && widx == 8'h76 |->
    avs_readdata[7:0] == rev8(sysref_out_gate)) else $error("gate read mismatch");
  src_write_a: assert property (wcom && widx == 8'h28 |=>
    {3'h0, sysref_src_sel[0], sysref_phase_dly[0], 1'b0} == ($past(wd) & 8'h1E)) else $error("source write wrong");
  drv_write_a: assert property (wcom && widx == 8'h2E |=>
    {out_power_down[2], 1'b0, bias_ctrl_n[2], drv_style_pecl[2], drv_amplitude[2], 2'b00} == ($past(wd) & 8'hBC))
    else $error("driver write wrong");
  quiet_hold_a: assert property (!wcom |=> $stable(sysref_out_gate) && $stable(sysref_src_sel)
    && $stable(out_power_down)) else $error("setting moved without write");
  gate_low_a: assert property ((sysref_output & (~$past(sysref_out_gate) | $past(out_power_down))) == 8'h00)
    else $error("gated output not low");
endmodule : osr_regs_asserts
bind osr_regs osr_regs_asserts chk_i (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_byteenable,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .sysref_output, .sysref_src_sel, .sysref_phase_dly,
  .out_power_down, .bias_ctrl_n, .drv_style_pecl, .drv_amplitude, .sysref_out_gate);

// ---- tb/osr_regs_tb.sv ----
// Self-checking bench for the sysref output state bank.
// Assumes osr_regs with an Avalon-MM slave on a 20 MHz clock.
`timescale 1ns/1ps
module osr_regs_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = '0;
  logic sysref_in = 1'b0;
  logic [3:0] chan_clk_in = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] sysref_output, sysref_src_sel, out_power_down, bias_ctrl_n, drv_style_pecl, sysref_out_gate;
  logic [7:0][2:0] sysref_phase_dly;
  logic [7:0][1:0] drv_amplitude;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] q, d;
  // Register indices per output, A0 first
  logic [7:0] src_idx [8] = '{8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58};
  logic [7:0] drv_idx [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h3C, 8'h3D, 8'h4C, 8'h4D, 8'h5C};
  osr_regs dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .sysref_in, .chan_clk_in, .sysref_output, .sysref_src_sel,
    .sysref_phase_dly, .out_power_down, .bias_ctrl_n, .drv_style_pecl, .drv_amplitude, .sysref_out_gate);
  initial forever #25 clk = ~clk;
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #1000000;
    err_count++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One bus access; held until waitrequest is sampled low, then settle to the falling edge
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
  endtask : acc
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8
  // Port fields of one output packed as in its registers
  function automatic logic [7:0] src_view(input int i);
    return {3'h0, sysref_src_sel[i], sysref_phase_dly[i], 1'b0};
  endfunction : src_view
  function automatic logic [7:0] drv_view(input int i);
    return {out_power_down[i], 1'b0, bias_ctrl_n[i], drv_style_pecl[i], drv_amplitude[i], 2'b00};
  endfunction : drv_view
  initial begin
    void'($urandom(32'hAE3E));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // Reset values: sysref source, zero delay, LVDS, powered, gates off
    for (int i = 0; i < 8; i++) begin
      acc(0, src_idx[i], 8'h00, q);
      chk(q & 8'h1E, 8'h10);
      acc(0, drv_idx[i], 8'h00, q);
      chk(q & 8'hBC, 8'h00);
    end
    acc(0, 8'h76, 8'h00, q);
    chk(q, 8'h00);
    chk(sysref_src_sel, 8'hFF);
    // Random fill, three passes, ports and read-back; reserved bits are masked
    repeat (3) begin
      for (int i = 0; i < 8; i++) begin
        d = 8'($urandom);
        acc(1, src_idx[i], d, q);
        chk(src_view(i), d & 8'h1E);
        acc(0, src_idx[i], 8'h00, q);
        chk(q & 8'h1E, d & 8'h1E);
        d = 8'($urandom);
        acc(1, drv_idx[i], d, q);
        chk(drv_view(i), d & 8'hBC);
        acc(0, drv_idx[i], 8'h00, q);
        chk(q & 8'hBC, d & 8'hBC);
      end
      d = 8'($urandom);
      acc(1, 8'h76, d, q);
      chk(sysref_out_gate, rev8(d));
      acc(0, 8'h76, 8'h00, q);
      chk(q, d);
    end
    // Low byte lane off: nothing lands
    @(posedge clk);
    avs_byteenable <= 4'hE;
    acc(1, 8'h76, ~d, q);
    chk(sysref_out_gate, rev8(d));
    @(posedge clk);
    avs_byteenable <= 4'hF;
    // Hole in the map reads zero
    acc(1, 8'h2B, 8'hFF, q);
    acc(0, 8'h2B, 8'h00, q);
    chk(q, 8'h00);
    // Signal path: sysref source, A1 powered down, some gates off
    for (int i = 0; i < 8; i++) begin
      acc(1, src_idx[i], 8'h10, q);
      acc(1, drv_idx[i], (i == 1) ? 8'h80 : 8'h00, q);
    end
    acc(1, 8'h76, 8'hD3, q);
    @(posedge clk);
    sysref_in <= 1'b1;
    repeat (20) @(negedge clk);
    chk(sysref_output, 8'hC9);
    // A0 from its channel clock with longest delay
    acc(1, src_idx[0], 8'h0E, q);
    @(posedge clk);
    sysref_in <= 1'b0;
    chan_clk_in <= 4'h1;
    // Old history has drained, the new level is still in the delay line
    repeat (10) @(negedge clk);
    chk(sysref_output, 8'h00);
    repeat (10) @(negedge clk);
    chk(sysref_output, 8'h01);
    acc(1, 8'h76, 8'h00, q);
    repeat (2) @(negedge clk);
    chk(sysref_output, 8'h00);
    print_verdict();
  end
endmodule : osr_regs_tb
